// ---- rtl/rrq_parity_check.sv ----
// package of shared constants and the completion byte-parity checker
// ----------------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------------
package rrq_pkg;
   // interface width selection codes (one-hot)
   localparam logic [2:0] RRQ_WIDTH_64  = 3'h1;
   localparam logic [2:0] RRQ_WIDTH_128 = 3'h2;
   localparam logic [2:0] RRQ_WIDTH_256 = 3'h4;
   // bus sizes
   localparam int RRQ_DATA_W     = 256;
   localparam int RRQ_KEEP_W     = 8;
   localparam int RRQ_SIDEBAND_W = 60;
   localparam int RRQ_PROG_W     = 4;
   localparam int RRQ_READY_W    = 4;
   localparam int RRQ_PAR_W      = 32;
   // completion sideband layout: bit 0 discontinue, parity in [32:1]
   localparam int RRQ_CPL_SB_W   = 33;
   localparam int RRQ_CPL_PAR_LO = 1;
   // parity lanes checked per width
   localparam logic [RRQ_PAR_W-1:0] RRQ_PAR_MASK_64  = 32'h0000_00FF;
   localparam logic [RRQ_PAR_W-1:0] RRQ_PAR_MASK_128 = 32'h0000_FFFF;
   localparam logic [RRQ_PAR_W-1:0] RRQ_PAR_MASK_256 = 32'hFFFF_FFFF;
   // keep lanes used per width
   localparam logic [RRQ_KEEP_W-1:0] RRQ_KEEP_MASK_64  = 8'h03;
   localparam logic [RRQ_KEEP_W-1:0] RRQ_KEEP_MASK_128 = 8'h0F;
   localparam logic [RRQ_KEEP_W-1:0] RRQ_KEEP_MASK_256 = 8'hFF;
   // reset values
   localparam logic [RRQ_PROG_W-1:0] RRQ_PROG_RST = 4'h0;
endpackage

// ----------------------------------------------------------------------------
// odd-parity check of each completion data byte within the lanes of the selected width
// ----------------------------------------------------------------------------
module rrq_parity_check
   import rrq_pkg::*;
(
   // configuration
   input  wire logic [2:0]           i_width_sel,
   input  wire logic                 i_parity_en,
   // data and parity under test
   input  wire logic [RRQ_DATA_W-1:0] i_data,
   input  wire logic [RRQ_PAR_W-1:0]  i_parity,
   // result
   output logic                       o_mismatch
);
   logic [RRQ_PAR_W-1:0] expect_par;
   logic [RRQ_PAR_W-1:0] lane_mask;

   // expected odd parity, one bit per byte
   always_comb begin
      for (int i = 0; i < RRQ_PAR_W; i++) begin
         expect_par[i] = ~(^i_data[i*8 +: 8]);
      end
   end

   always_comb begin
      if (i_width_sel == RRQ_WIDTH_64) begin
         lane_mask = RRQ_PAR_MASK_64;
      end else if (i_width_sel == RRQ_WIDTH_128) begin
         lane_mask = RRQ_PAR_MASK_128;
      end else begin
         lane_mask = RRQ_PAR_MASK_256;
      end
   end

   assign o_mismatch = i_parity_en & (|((expect_par ^ i_parity) & lane_mask));
endmodule

// ---- rtl/rrq_ingress.sv ----
// request ingress stage with completion parity checking
// Notes on behaviour
// - only low 16 parity bits checked at 128, low 8 at 64
// - parity mismatch discards the bad beat and the rest of its packet, sets internal error until reset
// - request bus 64/128/256 wide; unused high bits ignored
// - 60-bit request sideband meaningful only while request valid is high
// - keep [7:4] ignored at 128, [7:2] ignored at 64
// - beat moves only when valid and ready both high
// - four ready bits always driven together, all ones or zeros
// - progress number returned once request can no longer be overtaken
// - progress valid pulses for exactly one cycle per returned number
module rrq_ingress
   import rrq_pkg::*;
(
   // clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_b,
   // static configuration
   input  wire logic [2:0]                  i_width_sel,
   input  wire logic                        i_parity_en,
   // request stream from user
   input  wire logic [RRQ_DATA_W-1:0]       i_request_payload_bus,
   input  wire logic [RRQ_SIDEBAND_W-1:0]   i_request_sideband,
   input  wire logic                        i_request_end_marker,
   input  wire logic [RRQ_KEEP_W-1:0]       i_request_dword_keep,
   input  wire logic                        i_request_valid,
   input  wire logic [RRQ_PROG_W-1:0]       i_request_progress_in,
   output logic [RRQ_READY_W-1:0]           o_request_ready,
   // request stream to transmit pipeline
   output logic [RRQ_DATA_W-1:0]            o_tx_data,
   output logic [RRQ_SIDEBAND_W-1:0]        o_tx_sideband,
   output logic [RRQ_KEEP_W-1:0]            o_tx_keep,
   output logic                             o_tx_last,
   output logic                             o_tx_valid,
   input  wire logic                        i_tx_ready,
   // progress return
   output logic [RRQ_PROG_W-1:0]            o_request_progress_out,
   output logic                             o_request_progress_valid,
   // completion stream from user
   input  wire logic [RRQ_DATA_W-1:0]       i_completion_payload_bus,
   input  wire logic [RRQ_CPL_SB_W-1:0]     i_completion_sideband,
   input  wire logic                        i_completion_last,
   input  wire logic                        i_completion_valid,
   // completion stream onward
   output logic [RRQ_DATA_W-1:0]            o_cpl_data,
   output logic                             o_cpl_last,
   output logic                             o_cpl_valid,
   output logic                             o_cpl_discard,
   // error status
   output logic                             o_uncorrectable_error
);

   // ----------------------------------------------------------------------
   // types and helpers
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      PKT_IDLE = 2'h1,
      PKT_BODY = 2'h2
   } rrq_pkt_e;

   // data lanes used at the configured width
   function automatic logic [RRQ_DATA_W-1:0] data_mask(input logic [2:0] sel);
      logic [RRQ_DATA_W-1:0] m;
      m = '1;
      if (sel == RRQ_WIDTH_64) begin
         m = {{(RRQ_DATA_W-64){1'b0}}, {64{1'b1}}};
      end else if (sel == RRQ_WIDTH_128) begin
         m = {{(RRQ_DATA_W-128){1'b0}}, {128{1'b1}}};
      end
      return m;
   endfunction

   // keep lanes used at the configured width
   function automatic logic [RRQ_KEEP_W-1:0] keep_mask(input logic [2:0] sel);
      logic [RRQ_KEEP_W-1:0] m;
      m = RRQ_KEEP_MASK_256;
      if (sel == RRQ_WIDTH_64) begin
         m = RRQ_KEEP_MASK_64;
      end else if (sel == RRQ_WIDTH_128) begin
         m = RRQ_KEEP_MASK_128;
      end
      return m;
   endfunction

   // ----------------------------------------------------------------------
   // request path
   // ----------------------------------------------------------------------
   rrq_pkt_e                  req_state;
   rrq_pkt_e                  next_req_state;
   logic                      ready;
   logic                      next_ready;
   logic [RRQ_DATA_W-1:0]     tx_data;
   logic [RRQ_DATA_W-1:0]     next_tx_data;
   logic [RRQ_SIDEBAND_W-1:0] tx_sideband;
   logic [RRQ_SIDEBAND_W-1:0] next_tx_sideband;
   logic [RRQ_KEEP_W-1:0]     tx_keep;
   logic [RRQ_KEEP_W-1:0]     next_tx_keep;
   logic                      tx_last;
   logic                      next_tx_last;
   logic                      tx_valid;
   logic                      next_tx_valid;
   logic [RRQ_PROG_W-1:0]     pkt_prog;
   logic [RRQ_PROG_W-1:0]     next_pkt_prog;
   logic [RRQ_PROG_W-1:0]     prog_out;
   logic [RRQ_PROG_W-1:0]     next_prog_out;
   logic                      prog_vld;
   logic                      next_prog_vld;
   logic                      accept;
   logic                      drain;

   // beat moves on valid and ready
   assign accept = i_request_valid & ready;
   assign drain  = tx_valid & i_tx_ready;

   // request next-state logic
   always_comb begin
      next_req_state   = req_state;
      next_tx_data     = tx_data;
      next_tx_sideband = tx_sideband;
      next_tx_keep     = tx_keep;
      next_tx_last     = tx_last;
      next_tx_valid    = tx_valid & ~drain;
      next_pkt_prog    = pkt_prog;
      next_prog_out    = prog_out;
      next_prog_vld    = 1'b0;
      if (accept) begin
         next_tx_data     = i_request_payload_bus & data_mask(i_width_sel);
         next_tx_sideband = i_request_sideband;
         next_tx_keep     = i_request_dword_keep & keep_mask(i_width_sel);
         next_tx_last     = i_request_end_marker;
         next_tx_valid    = 1'b1;
      end
      // packet framing tracks the first beat for the progress number
      case (req_state)
         PKT_IDLE: begin
            if (accept) begin
               next_pkt_prog = i_request_progress_in;
               if (!i_request_end_marker) begin
                  next_req_state = PKT_BODY;
               end
            end
         end
         PKT_BODY: begin
            if (accept && i_request_end_marker) begin
               next_req_state = PKT_IDLE;
            end
         end
         default: begin
            next_req_state = PKT_IDLE;
         end
      endcase
      // returned when last beat leaves into pipeline
      if (drain && tx_last) begin
         next_prog_vld = 1'b1;
         next_prog_out = pkt_prog;
      end
      // a single stage: ready only while the slot will be empty,
      // trading half throughput for a registered ready
      next_ready = ~next_tx_valid;
   end

   // request registers
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         req_state   <= PKT_IDLE;
         ready       <= 1'b0;
         tx_data     <= '0;
         tx_sideband <= '0;
         tx_keep     <= '0;
         tx_last     <= 1'b0;
         tx_valid    <= 1'b0;
         pkt_prog    <= RRQ_PROG_RST;
         prog_out    <= RRQ_PROG_RST;
         prog_vld    <= 1'b0;
      end else begin
         req_state   <= next_req_state;
         ready       <= next_ready;
         tx_data     <= next_tx_data;
         tx_sideband <= next_tx_sideband;
         tx_keep     <= next_tx_keep;
         tx_last     <= next_tx_last;
         tx_valid    <= next_tx_valid;
         pkt_prog    <= next_pkt_prog;
         prog_out    <= next_prog_out;
         prog_vld    <= next_prog_vld;
      end
   end

   // all ready bits from one flop
   assign o_request_ready          = {RRQ_READY_W{ready}};
   assign o_tx_data                = tx_data;
   assign o_tx_sideband            = tx_sideband;
   assign o_tx_keep                = tx_keep;
   assign o_tx_last                = tx_last;
   assign o_tx_valid               = tx_valid;
   assign o_request_progress_out   = prog_out;
   assign o_request_progress_valid = prog_vld;

   // ----------------------------------------------------------------------
   // completion parity path
   // ----------------------------------------------------------------------
   logic                  par_err;
   logic                  cpl_bad;
   logic                  next_cpl_bad;
   logic [RRQ_DATA_W-1:0] cpl_data;
   logic [RRQ_DATA_W-1:0] next_cpl_data;
   logic                  cpl_last;
   logic                  next_cpl_last;
   logic                  cpl_valid;
   logic                  next_cpl_valid;
   logic                  cpl_discard;
   logic                  next_cpl_discard;
   logic                  int_err;
   logic                  next_int_err;

   // per-beat byte parity check
   rrq_parity_check u_par (
      .i_width_sel (i_width_sel),
      .i_parity_en (i_parity_en),
      .i_data      (i_completion_payload_bus),
      .i_parity    (i_completion_sideband[RRQ_CPL_PAR_LO +: RRQ_PAR_W]),
      .o_mismatch  (par_err)
   );

   // completion next-state logic
   always_comb begin
      next_cpl_data    = cpl_data;
      next_cpl_last    = cpl_last;
      next_cpl_valid   = i_completion_valid;
      next_cpl_discard = 1'b0;
      next_cpl_bad     = cpl_bad;
      next_int_err     = int_err;
      if (i_completion_valid) begin
         next_cpl_data = i_completion_payload_bus;
         next_cpl_last = i_completion_last;
         // bad beat poisons rest of packet
         next_cpl_discard = cpl_bad | par_err;
         next_cpl_bad     = (cpl_bad | par_err) & ~i_completion_last;
         next_int_err     = int_err | par_err;
      end
   end

   // completion registers
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cpl_data    <= '0;
         cpl_last    <= 1'b0;
         cpl_valid   <= 1'b0;
         cpl_discard <= 1'b0;
         cpl_bad     <= 1'b0;
         int_err     <= 1'b0;
      end else begin
         cpl_data    <= next_cpl_data;
         cpl_last    <= next_cpl_last;
         cpl_valid   <= next_cpl_valid;
         cpl_discard <= next_cpl_discard;
         cpl_bad     <= next_cpl_bad;
         int_err     <= next_int_err;
      end
   end

   assign o_cpl_data            = cpl_data;
   assign o_cpl_last            = cpl_last;
   assign o_cpl_valid           = cpl_valid;
   assign o_cpl_discard         = cpl_discard;
   assign o_uncorrectable_error = int_err;
endmodule

// ---- verification/rrq_ingress_monitor.sv ----
// port checker for the request ingress block, bound into rrq_ingress
// ---------------------------------------------------------------------
// checker module
// ---------------------------------------------------------------------
module rrq_ingress_monitor
   import rrq_pkg::*;
(
   // clock, reset, configuration
   input wire logic                    i_mclk,
   input wire logic                    i_rst_b,
   input wire logic [2:0]              i_width_sel,
   input wire logic                    i_parity_en,
   // request side
   input wire logic [RRQ_DATA_W-1:0]   i_request_payload_bus,
   input wire logic [RRQ_KEEP_W-1:0]   i_request_dword_keep,
   input wire logic                    i_request_valid,
   input wire logic [RRQ_READY_W-1:0]  o_request_ready,
   input wire logic [RRQ_DATA_W-1:0]   o_tx_data,
   input wire logic [RRQ_KEEP_W-1:0]   o_tx_keep,
   input wire logic                    o_tx_last,
   input wire logic                    o_tx_valid,
   input wire logic                    i_tx_ready,
   input wire logic                    o_request_progress_valid,
   // completion side
   input wire logic [RRQ_DATA_W-1:0]   i_completion_payload_bus,
   input wire logic [RRQ_CPL_SB_W-1:0] i_completion_sideband,
   input wire logic                    i_completion_valid,
   input wire logic                    o_cpl_valid,
   input wire logic                    o_cpl_discard,
   input wire logic                    o_uncorrectable_error
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [RRQ_DATA_W-1:0] dmask;
   logic [RRQ_KEEP_W-1:0] kmask;
   logic                  bad;
   // lanes in use; byte i sits in dword i/4, so one mask serves data and parity
   always_comb begin
      kmask = (i_width_sel == RRQ_WIDTH_64) ? RRQ_KEEP_MASK_64 :
              (i_width_sel == RRQ_WIDTH_128) ? RRQ_KEEP_MASK_128 : RRQ_KEEP_MASK_256;
      bad = 1'h0;
      for (int i = 0; i < 32; i++) begin
         dmask[i*8+:8] = {8{kmask[i/4]}};
         if (kmask[i/4] && !(^{i_completion_payload_bus[i*8+:8], i_completion_sideband[i+1]})) bad = 1'h1;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // beat taken, and last beat drained downstream
   sequence s_take; i_request_valid && o_request_ready == 4'hF; endsequence
   sequence s_drain_last; o_tx_valid && i_tx_ready && o_tx_last; endsequence
   a_ready_all_same: assert property (o_request_ready == 4'h0 || o_request_ready == 4'hF)
      else $error("ready lanes differ");
   a_take_fills: assert property (s_take |=> o_tx_valid && o_request_ready == 4'h0)
      else $error("taken beat not forwarded");
   a_idle_stays: assert property (!i_request_valid && !o_tx_valid |=> !o_tx_valid)
      else $error("beat appeared without valid");
   a_data_masked: assert property (s_take |=> o_tx_data == ($past(i_request_payload_bus) & dmask))
      else $error("forwarded data wrong");
   a_keep_masked: assert property (s_take |=> o_tx_keep == ($past(i_request_dword_keep) & kmask))
      else $error("forwarded keep wrong");
   a_prog_after_last: assert property (s_drain_last |=> o_request_progress_valid)
      else $error("progress not returned");
   a_prog_one_cycle: assert property (o_request_progress_valid |=> !o_request_progress_valid)
      else $error("progress valid too long");
   a_bad_par_drop: assert property (i_completion_valid && i_parity_en && bad |=>
      o_cpl_valid && o_cpl_discard && o_uncorrectable_error)
      else $error("parity fault not flagged");
   a_err_sticky: assert property (o_uncorrectable_error |=> o_uncorrectable_error)
      else $error("error flag cleared");
   a_clean_passes: assert property (i_completion_valid && (!bad || !i_parity_en) && !o_uncorrectable_error
      |=> o_cpl_valid && !o_cpl_discard)
      else $error("clean beat discarded");
endmodule
bind rrq_ingress rrq_ingress_monitor u_mon (
   .i_mclk                   (i_mclk),
   .i_rst_b                  (i_rst_b),
   .i_width_sel              (i_width_sel),
   .i_parity_en              (i_parity_en),
   .i_request_payload_bus    (i_request_payload_bus),
   .i_request_dword_keep     (i_request_dword_keep),
   .i_request_valid          (i_request_valid),
   .o_request_ready          (o_request_ready),
   .o_tx_data                (o_tx_data),
   .o_tx_keep                (o_tx_keep),
   .o_tx_last                (o_tx_last),
   .o_tx_valid               (o_tx_valid),
   .i_tx_ready               (i_tx_ready),
   .o_request_progress_valid (o_request_progress_valid),
   .i_completion_payload_bus (i_completion_payload_bus),
   .i_completion_sideband    (i_completion_sideband),
   .i_completion_valid       (i_completion_valid),
   .o_cpl_valid              (o_cpl_valid),
   .o_cpl_discard            (o_cpl_discard),
   .o_uncorrectable_error    (o_uncorrectable_error)
);

// ---- verification/rrq_user_model.sv ----
// user-side model: issues request and completion beats
module rrq_user_model
   import rrq_pkg::*;
(
   // clock and pacing
   input  wire logic                    i_mclk,
   input  wire logic [RRQ_READY_W-1:0]  i_ready,
   // request stream
   output logic [RRQ_DATA_W-1:0]        o_data = '0,
   output logic [RRQ_SIDEBAND_W-1:0]    o_sb = '0,
   output logic [RRQ_KEEP_W-1:0]        o_keep = '0,
   output logic [RRQ_PROG_W-1:0]        o_prog = '0,
   output logic                         o_last = 1'h0,
   output logic                         o_valid = 1'h0,
   // completion stream
   output logic [RRQ_DATA_W-1:0]        o_cdata = '0,
   output logic [RRQ_CPL_SB_W-1:0]      o_csb = '0,
   output logic                         o_clast = 1'h0,
   output logic                         o_cvalid = 1'h0
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic req_beat(input logic [255:0] d, input logic [59:0] s, input logic [7:0] k, input logic l,
                           input logic [3:0] p);
      {o_data, o_sb, o_keep, o_last, o_prog, o_valid} <= {d, s, k, l, p, 1'h1};
      for (int n = 0; n < 64; n++) begin
         @(posedge i_mclk);
         if (i_ready === 4'hF) return;
      end
      tb.hang();
   endtask
   // released data and sideband lines show no stale value
   task automatic req_idle();
      {o_valid, o_data, o_sb} <= {1'h0, ~o_data, ~o_sb};
   endtask
   // odd parity per byte, or tied low
   task automatic cpl_beat(input logic [255:0] d, input logic [31:0] flip, input logic zero, l);
      logic [31:0] p;
      for (int i = 0; i < 32; i++) p[i] = ~^d[i*8+:8];
      {o_cdata, o_csb, o_clast, o_cvalid} <= {d, zero ? 32'h0 : p ^ flip, 1'h0, l, 1'h1};
      @(posedge i_mclk);
   endtask
   task automatic cpl_idle();
      {o_cvalid, o_cdata} <= {1'h0, ~o_cdata};
   endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the request ingress block
module tb
   import rrq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  i_mclk = 1'h0, i_rst_b = 1'h0, par_en = 1'h0, tx_ready = 1'h0;
   logic [2:0]            wsel = RRQ_WIDTH_256;
   logic [RRQ_DATA_W-1:0] rdata, cdata, tx_data, cpl_data;
   logic [59:0]           rsb, tx_sb;
   logic [7:0]            rkeep, tx_keep;
   logic [3:0]            rdy, rprog, prog;
   logic [32:0]           csb;
   logic                  rlast, rvalid, clast, cvalid, tx_last, tx_valid, prog_v, cpl_last, cpl_v, cpl_disc, err;
   int                    n_fail = 0, compares = 0;
   logic [324:0]          q_tx[$];
   logic [257:0]          q_cpl[$];
   logic [3:0]            q_prog[$];
   rrq_ingress DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_width_sel(wsel), .i_parity_en(par_en),
      .i_request_payload_bus(rdata), .i_request_sideband(rsb), .i_request_end_marker(rlast),
      .i_request_dword_keep(rkeep), .i_request_valid(rvalid), .i_request_progress_in(rprog),
      .o_request_ready(rdy), .o_tx_data(tx_data), .o_tx_sideband(tx_sb), .o_tx_keep(tx_keep),
      .o_tx_last(tx_last), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_request_progress_out(prog),
      .o_request_progress_valid(prog_v), .i_completion_payload_bus(cdata), .i_completion_sideband(csb),
      .i_completion_last(clast), .i_completion_valid(cvalid), .o_cpl_data(cpl_data), .o_cpl_last(cpl_last),
      .o_cpl_valid(cpl_v), .o_cpl_discard(cpl_disc), .o_uncorrectable_error(err));
   rrq_user_model u_user (.i_mclk(i_mclk), .i_ready(rdy), .o_data(rdata), .o_sb(rsb), .o_keep(rkeep),
      .o_prog(rprog), .o_last(rlast), .o_valid(rvalid), .o_cdata(cdata), .o_csb(csb), .o_clast(clast),
      .o_cvalid(cvalid));
   // clock, and a downstream that stalls at random
   initial forever #12.5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) tx_ready <= 1'($urandom_range(1));
   // ---------------------------------------------------------------
   // compare and report
   // ---------------------------------------------------------------
   task automatic chk_beat(input logic [329:0] e, g);
      compares++;
      if (e !== g) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%0h got=%0h", $time, e, g);
      end
   endtask
   task automatic chk_small(input logic [3:0] e, g);
      chk_beat(330'(e), 330'(g));
   endtask
   task automatic stop_test();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      stop_test();
   endtask
   // scoreboard: oldest note against each result as it appears
   always @(posedge i_mclk) begin
      if (tx_valid && tx_ready) chk_beat(330'(q_tx.pop_front()), 330'({tx_data, tx_sb, tx_keep, tx_last}));
      if (prog_v) chk_small(q_prog.pop_front(), prog);
      if (cpl_v) chk_beat(330'(q_cpl.pop_front()), 330'({cpl_disc, cpl_last, cpl_data}));
   end
   // completion beat with its expected outcome noted first
   task automatic cpl(input logic [255:0] d, input logic [31:0] flip, input logic zero, l, disc);
      q_cpl.push_back({disc, l, d});
      u_user.cpl_beat(d, flip, zero, l);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int nb, wb;
      logic [255:0] d;
      logic [59:0] s;
      logic [7:0] k;
      logic [3:0] p;
      void'($urandom(32'h04ebccb9));
      repeat (20) @(posedge i_mclk);
      i_rst_b <= 1'h1;
      repeat (2) @(posedge i_mclk);
      for (int w = 0; w < 3; w++) begin
         wb = 64 << w;
         wsel <= 3'(1 << w); // one-hot, same order as the width codes
         par_en <= 1'h1;
         p = 4'($urandom);
         q_prog.push_back(p);
         nb = (w == 2) ? 1 : 3;
         for (int b = 0; b < nb; b++) begin
            d = {8{$urandom}};
            s = 60'({$urandom, $urandom});
            // partial keep only in final beat
            k = (b == nb - 1) ? 8'hFF >> $urandom_range(7) : 8'hFF;
            q_tx.push_back({d & ({256{1'h1}} >> (256 - wb)), s, k & (8'hFF >> (8 - wb / 32)), b == nb - 1});
            u_user.req_beat(d, s, k, b == nb - 1, p);
         end
         u_user.req_idle();
         d = {8{$urandom}};
         cpl(d, (w < 2) ? 32'h1 << (wb / 8) : 32'h0, 1'h0, 1'h0, 1'h0);
         cpl(~d, 32'h0, 1'h0, 1'h1, 1'h0);
         par_en <= 1'h0;
         cpl(d, 32'h0, 1'h1, 1'h1, 1'h0);
         u_user.cpl_idle();
         repeat (2) @(posedge i_mclk);
         #1 chk_small(4'h0, 4'(err));
      end
      for (int n = 0; n < 300 && q_tx.size() + q_prog.size() > 0; n++) @(posedge i_mclk);
      // drain that never finished counts as a mismatch
      if (q_tx.size() + q_prog.size() > 0) n_fail++;
      wsel <= RRQ_WIDTH_64;
      par_en <= 1'h1;
      d = {8{$urandom}};
      // top checked lane at 64 bits, later beat dropped too
      cpl(d, 32'h80, 1'h0, 1'h0, 1'h1);
      cpl(d, 32'h0, 1'h0, 1'h1, 1'h1);
      u_user.cpl_idle();
      par_en <= 1'h0;
      repeat (6) @(posedge i_mclk);
      #1 chk_small(4'h1, 4'(err));
      @(posedge i_mclk);
      i_rst_b <= 1'h0;
      repeat (2) @(posedge i_mclk);
      i_rst_b <= 1'h1;
      #1 chk_small(4'h0, 4'(err));
      chk_small(4'h0, 4'(q_tx.size() + q_cpl.size() + q_prog.size()));
      stop_test();
   end
endmodule
